// [design/ppslc_top.sv]
// Device status and link capability registers of one switch port
// Summary of operation
// RQ1: Correctable error sets status bit 16; sticky, write one clears, resets zero.
// RQ2: Non-fatal error sets status bit 17; write one clears, resets zero.
// RQ3: Fatal error sets status bit 18; write one clears, resets zero.
// RQ4: Unsupported request sets status bit 19; write one clears, resets zero.
// RQ5: Error flags log regardless of the reporting enables in device control.
// RQ6: Status bit 20 shows auxiliary power present, read only, resets one.
// RQ7: Transactions pending bit 21 always reads zero.
// RQ8: Max link speed in bits 3:0, 1 is 2.5G, 2 is 5G, resets 2.
// RQ9: Max width bits 9:4, x4 on upstream in four-lane mode, else x1.
// RQ10: ASPM support bits 11:10 read only, resets to zero.
// RQ11: L0s exit latency code bits 14:12 resets to three.
// RQ12: L1 exit latency code bits 17:15 resets to zero.
// RQ13: Clock power management bit 18 is one upstream, zero downstream.
// RQ14: Data link active reporting bit 20 one downstream, zero upstream.
// RQ15: Bandwidth notification bit 21 reads zero on every port.
// RQ16: Port number in bits 31:24 resets to the port index.
// RQ17: Loadable capability defaults may be overwritten by the serial loader.
// RQ18: Only a written one clears a status bit; reserved bits read zero.
`timescale 1ns/1ps
`include "ppslc_regs.svh"

module ppslc_top import ppslc_pkg::*; #(
  parameter logic [7:0] PORT_INDEX = 8'h00,
  parameter bit IS_UPSTREAM = 1'b1,
  parameter bit X4_MODE = 1'b0
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Configuration register port
  input wire logic CFG_RD_I,
  input wire logic CFG_WR_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [31:0] CFG_WDATA_I,
  input wire logic [3:0] CFG_BE_I,
  output logic [31:0] CFG_RDATA_O,
  output logic CFG_RVALID_O,
  // Error events from the port
  input wire ppslc_err_t ERR_EVT_I,
  input wire logic AUX_PWR_I,
  // Serial loader capability override
  input wire ppslc_load_t LOAD_I,
  // Capability fields and error flags for the link logic
  output ppslc_caps_t LINK_CAPS_O,
  output logic [3:0] ERR_STATUS_O
);

  // Refuse configurations that no port of the switch can take
  if (PORT_INDEX > 8'h05) begin : g_bad_index
    $error("PORT_INDEX out of range");
  end
  if (X4_MODE && !IS_UPSTREAM) begin : g_bad_x4
    $error("X4_MODE applies to the upstream port only");
  end

  ppslc_state_t st_ff;
  ppslc_state_t nxt_st;
  ppslc_caps_t caps_rst;
  ppslc_err_t clr;
  logic wr_stat;

  always_comb begin
    caps_rst = '0;
    caps_rst.max_speed = `PPSLC_SPEED_RST; // see RQ8
    caps_rst.max_width = (IS_UPSTREAM && X4_MODE) ? `PPSLC_WIDTH_X4 : `PPSLC_WIDTH_X1; // see RQ9
    caps_rst.aspm = `PPSLC_ASPM_RST; // see RQ10
    caps_rst.l0s_lat = `PPSLC_L0S_LAT_RST; // see RQ11
    caps_rst.l1_lat = `PPSLC_L1_LAT_RST; // see RQ12
    caps_rst.clk_pm = IS_UPSTREAM ? `PPSLC_CLKPM_RST : 1'h0; // see RQ13
    caps_rst.surprise = `PPSLC_SURPRISE_RST;
    caps_rst.dlla_rep = IS_UPSTREAM ? 1'h0 : `PPSLC_DLLA_RST; // see RQ14
    caps_rst.bw_notify = 1'h0; // see RQ15
    caps_rst.port_num = PORT_INDEX; // see RQ16
  end

  // Status bits sit in byte lane 2, so clears need that lane enabled
  assign wr_stat = CFG_WR_I && CFG_BE_I[2] && (CFG_ADDR_I == `PPSLC_OFF_ERR_STATUS);

  always_comb begin
    clr.corr = wr_stat && CFG_WDATA_I[`PPSLC_ST_CORR_BIT]; // see RQ18
    clr.nonfatal = wr_stat && CFG_WDATA_I[`PPSLC_ST_NONFATAL_BIT];
    clr.fatal = wr_stat && CFG_WDATA_I[`PPSLC_ST_FATAL_BIT];
    clr.unsup = wr_stat && CFG_WDATA_I[`PPSLC_ST_UNSUP_BIT];
  end

  always_comb begin
    nxt_st = st_ff;
    // Set beats clear so an event on the clearing write is not lost
    nxt_st.err = (st_ff.err & ~clr) | ERR_EVT_I; // see RQ1, RQ2, RQ3, RQ4, RQ5
    nxt_st.aux = AUX_PWR_I; // see RQ6
    if (LOAD_I.valid) begin // see RQ17
      nxt_st.caps.aspm = LOAD_I.aspm;
      nxt_st.caps.l0s_lat = LOAD_I.l0s_lat;
      nxt_st.caps.l1_lat = LOAD_I.l1_lat;
      nxt_st.caps.clk_pm = IS_UPSTREAM ? LOAD_I.clk_pm : 1'h0; // see RQ13
      nxt_st.caps.surprise = LOAD_I.surprise;
      nxt_st.caps.dlla_rep = IS_UPSTREAM ? 1'h0 : LOAD_I.dlla_rep; // see RQ14
      nxt_st.caps.port_num = LOAD_I.port_num;
    end
    nxt_st.caps.bw_notify = 1'h0; // see RQ15
    nxt_st.caps.rsvd_hi = 2'h0;
    nxt_st.rvalid = 1'b0;
    case (st_ff.rd_st)
      PPSLC_IDLE: begin
        if (CFG_RD_I) begin
          nxt_st.rvalid = 1'b1;
          nxt_st.rd_st = PPSLC_READ;
          case (CFG_ADDR_I)
            `PPSLC_OFF_ERR_STATUS: begin
              nxt_st.rdata = '0; // see RQ18
              nxt_st.rdata[`PPSLC_ST_CORR_BIT] = st_ff.err.corr;
              nxt_st.rdata[`PPSLC_ST_NONFATAL_BIT] = st_ff.err.nonfatal;
              nxt_st.rdata[`PPSLC_ST_FATAL_BIT] = st_ff.err.fatal;
              nxt_st.rdata[`PPSLC_ST_UNSUP_BIT] = st_ff.err.unsup;
              nxt_st.rdata[`PPSLC_ST_AUX_BIT] = st_ff.aux;
              nxt_st.rdata[`PPSLC_ST_PEND_BIT] = 1'b0; // see RQ7
            end
            `PPSLC_OFF_LINK_CAPS: begin
              nxt_st.rdata = st_ff.caps;
            end
            default: begin
              nxt_st.rdata = '0;
            end
          endcase
        end
      end
      PPSLC_READ: begin
        // One idle cycle between reads keeps each answer a clean pulse
        nxt_st.rd_st = PPSLC_IDLE;
      end
      default: begin
        nxt_st.rd_st = PPSLC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_ff.err <= '0;
      st_ff.aux <= `PPSLC_ST_AUX_RST;
      st_ff.caps <= caps_rst;
      st_ff.rdata <= '0;
      st_ff.rvalid <= 1'b0;
      st_ff.rd_st <= PPSLC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign CFG_RDATA_O = st_ff.rdata;
  assign CFG_RVALID_O = st_ff.rvalid;
  assign LINK_CAPS_O = st_ff.caps;
  assign ERR_STATUS_O = st_ff.err;

  sequence s_evt_corr;
    ERR_EVT_I.corr;
  endsequence

  sequence s_flag_held;
    st_ff.err.corr [*2];
  endsequence

  a_corr_set_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_evt_corr ##1 !clr.corr |-> s_flag_held) // see RQ1
    else $error("correctable flag not held");
  a_nonfatal_set: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ERR_EVT_I.nonfatal |=> st_ff.err.nonfatal) // see RQ2
    else $error("non-fatal flag not set");
  a_fatal_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    st_ff.err.fatal && clr.fatal && !ERR_EVT_I.fatal |=> !st_ff.err.fatal) // see RQ3
    else $error("fatal flag not cleared");
  a_unsup_set: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ERR_EVT_I.unsup |=> st_ff.err.unsup) // see RQ4
    else $error("unsupported flag not set");
  a_zero_keeps_flag: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    st_ff.err.corr && !clr.corr |=> st_ff.err.corr) // see RQ18
    else $error("flag lost without a one written");
  a_flag_only_by_event: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !st_ff.err.fatal && !ERR_EVT_I.fatal |=> !st_ff.err.fatal) // see RQ5
    else $error("flag set without an event");
  a_read_status_pulse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CFG_RD_I && st_ff.rd_st == PPSLC_IDLE && CFG_ADDR_I == `PPSLC_OFF_ERR_STATUS
    |=> CFG_RVALID_O && CFG_RDATA_O[31:22] == 10'h000 && !CFG_RDATA_O[21]
    && CFG_RDATA_O[20] == $past(st_ff.aux) ##1 !CFG_RVALID_O) // see RQ7
    else $error("status read answer wrong");
  a_bw_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !LINK_CAPS_O.bw_notify && LINK_CAPS_O.max_speed == `PPSLC_SPEED_RST) // see RQ15
    else $error("bandwidth notify or speed wrong");
  a_role_bits: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    IS_UPSTREAM ? !LINK_CAPS_O.dlla_rep : !LINK_CAPS_O.clk_pm) // see RQ14
    else $error("role hardwired bit wrong");
  a_load_port: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    LOAD_I.valid |=> LINK_CAPS_O.port_num == $past(LOAD_I.port_num)) // see RQ17
    else $error("loaded port number not taken");
  a_aux_follow: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    1'b1 |=> st_ff.aux == $past(AUX_PWR_I)) // see RQ6
    else $error("aux power not reflected");
  a_corr_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    st_ff.err.corr && clr.corr && !ERR_EVT_I.corr |=> !st_ff.err.corr) // see RQ1
    else $error("correctable flag not cleared");
  a_nonfatal_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    st_ff.err.nonfatal && clr.nonfatal && !ERR_EVT_I.nonfatal |=> !st_ff.err.nonfatal) // see RQ2
    else $error("non-fatal flag not cleared");
  a_unsup_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    st_ff.err.unsup && clr.unsup && !ERR_EVT_I.unsup |=> !st_ff.err.unsup) // see RQ4
    else $error("unsupported flag not cleared");
  a_set_beats_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ERR_EVT_I.fatal && clr.fatal |=> st_ff.err.fatal) // see RQ3
    else $error("event lost to a clear");
  a_caps_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CFG_RD_I && st_ff.rd_st == PPSLC_IDLE && CFG_ADDR_I == `PPSLC_OFF_LINK_CAPS
    |=> CFG_RVALID_O && CFG_RDATA_O == $past(LINK_CAPS_O)) // see RQ8
    else $error("capability read answer wrong");
  a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CFG_RD_I && st_ff.rd_st == PPSLC_IDLE && CFG_ADDR_I != `PPSLC_OFF_LINK_CAPS
    && CFG_ADDR_I != `PPSLC_OFF_ERR_STATUS |=> CFG_RDATA_O == 32'h0) // see RQ18
    else $error("unmapped read not zero");
  a_caps_rsvd: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    LINK_CAPS_O.rsvd_hi == 2'h0) // see RQ18
    else $error("reserved capability bits set");
  a_width_fixed: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    LINK_CAPS_O.max_width == ((IS_UPSTREAM && X4_MODE) ? 6'h04 : 6'h01)) // see RQ9
    else $error("maximum width wrong");
  a_load_lat: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    LOAD_I.valid |=> LINK_CAPS_O.l0s_lat == $past(LOAD_I.l0s_lat)
    && LINK_CAPS_O.l1_lat == $past(LOAD_I.l1_lat)) // see RQ11
    else $error("loaded latencies not taken");
  a_caps_stable: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !LOAD_I.valid |=> $stable(LINK_CAPS_O)) // see RQ17
    else $error("capabilities changed without a load");
  a_rvalid_pulse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CFG_RVALID_O |=> !CFG_RVALID_O) // see RQ18
    else $error("read answer longer than one cycle");

endmodule

// [design/ppslc_regs.svh]
// Register offsets, field positions, reset values and codes of the port status block
`ifndef PPSLC_REGS_SVH
`define PPSLC_REGS_SVH

`define PPSLC_OFF_ERR_STATUS 8'hC8
`define PPSLC_OFF_LINK_CAPS 8'hCC

`define PPSLC_ST_CORR_BIT 16
`define PPSLC_ST_NONFATAL_BIT 17
`define PPSLC_ST_FATAL_BIT 18
`define PPSLC_ST_UNSUP_BIT 19
`define PPSLC_ST_AUX_BIT 20
`define PPSLC_ST_PEND_BIT 21
`define PPSLC_ST_AUX_RST 1'h1

`define PPSLC_SPEED_2G5 4'h1
`define PPSLC_SPEED_5G0 4'h2
`define PPSLC_SPEED_RST 4'h2
`define PPSLC_WIDTH_X4 6'h04
`define PPSLC_WIDTH_X1 6'h01
`define PPSLC_ASPM_RST 2'h0
`define PPSLC_L0S_LAT_RST 3'h3
`define PPSLC_L1_LAT_RST 3'h0
`define PPSLC_CLKPM_RST 1'h1
`define PPSLC_SURPRISE_RST 1'h0
`define PPSLC_DLLA_RST 1'h1

`define PPSLC_L0S_EXIT_MIN_NS 256
`define PPSLC_L1_EXIT_MIN_US 16
`define PPSLC_CLK_PERIOD_NS 20
`define PPSLC_L0S_EXIT_CYC ((`PPSLC_L0S_EXIT_MIN_NS + `PPSLC_CLK_PERIOD_NS - 1) / `PPSLC_CLK_PERIOD_NS)

`endif

// [design/ppslc_pkg.sv]
// Types shared by the port status and link capability block
package ppslc_pkg;

  typedef struct packed {
    logic [7:0] port_num;
    logic [1:0] rsvd_hi;
    logic bw_notify;
    logic dlla_rep;
    logic surprise;
    logic clk_pm;
    logic [2:0] l1_lat;
    logic [2:0] l0s_lat;
    logic [1:0] aspm;
    logic [5:0] max_width;
    logic [3:0] max_speed;
  } ppslc_caps_t;

  typedef struct packed {
    logic corr;
    logic nonfatal;
    logic fatal;
    logic unsup;
  } ppslc_err_t;

  typedef struct packed {
    logic valid;
    logic [1:0] aspm;
    logic [2:0] l0s_lat;
    logic [2:0] l1_lat;
    logic clk_pm;
    logic surprise;
    logic dlla_rep;
    logic [7:0] port_num;
  } ppslc_load_t;

  typedef enum logic [1:0] {
    PPSLC_IDLE,
    PPSLC_READ
  } ppslc_rd_state_t;

  typedef struct packed {
    ppslc_err_t err;
    logic aux;
    ppslc_caps_t caps;
    logic [31:0] rdata;
    logic rvalid;
    ppslc_rd_state_t rd_st;
  } ppslc_state_t;

endpackage

// [sim/pcie_port_status_link_caps_bench.sv]
// Self-checking bench for the port status and link capability registers
`timescale 1ns/1ps

module pcie_port_status_link_caps_bench;
  import ppslc_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic CFG_RD_I = 1'b0;
  logic CFG_WR_I = 1'b0;
  logic [7:0] CFG_ADDR_I = 8'h00;
  logic [31:0] CFG_WDATA_I = 32'h0;
  logic [3:0] CFG_BE_I = 4'h0;
  logic [31:0] CFG_RDATA_O;
  logic CFG_RVALID_O;
  ppslc_err_t ERR_EVT_I = '0;
  logic AUX_PWR_I = 1'b1;
  ppslc_load_t LOAD_I = '0;
  ppslc_caps_t LINK_CAPS_O;
  logic [3:0] ERR_STATUS_O;
  int error_cnt = 0;
  int comparisons = 0;
  // Model state: flags as status bits 19:16, capability word
  logic [3:0] m_st = 4'h0;
  logic [31:0] m_caps = 32'h0304_3042;
  logic [31:0] dn_rdata;
  logic dn_rvalid;
  ppslc_caps_t dn_caps;
  logic [3:0] dn_err;
  logic [31:0] d;
  ppslc_err_t e;

  // Upstream port 3 in the four-lane configuration
  ppslc_top #(.PORT_INDEX(8'h03), .IS_UPSTREAM(1'b1), .X4_MODE(1'b1)) dut (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CFG_RD_I(CFG_RD_I), .CFG_WR_I(CFG_WR_I),
    .CFG_ADDR_I(CFG_ADDR_I), .CFG_WDATA_I(CFG_WDATA_I), .CFG_BE_I(CFG_BE_I),
    .CFG_RDATA_O(CFG_RDATA_O), .CFG_RVALID_O(CFG_RVALID_O), .ERR_EVT_I(ERR_EVT_I),
    .AUX_PWR_I(AUX_PWR_I), .LOAD_I(LOAD_I), .LINK_CAPS_O(LINK_CAPS_O),
    .ERR_STATUS_O(ERR_STATUS_O)
  );

  // Downstream port 5 shares the stimulus; only its reset capabilities are compared
  ppslc_top #(.PORT_INDEX(8'h05), .IS_UPSTREAM(1'b0), .X4_MODE(1'b0)) dut_dn (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CFG_RD_I(CFG_RD_I), .CFG_WR_I(CFG_WR_I),
    .CFG_ADDR_I(CFG_ADDR_I), .CFG_WDATA_I(CFG_WDATA_I), .CFG_BE_I(CFG_BE_I),
    .CFG_RDATA_O(dn_rdata), .CFG_RVALID_O(dn_rvalid), .ERR_EVT_I(ERR_EVT_I),
    .AUX_PWR_I(AUX_PWR_I), .LOAD_I(LOAD_I), .LINK_CAPS_O(dn_caps),
    .ERR_STATUS_O(dn_err)
  );

  always #10 CLK_I = ~CLK_I;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One read; a second read waits an idle cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(negedge CLK_I);
    CFG_RD_I = 1'b1;
    CFG_ADDR_I = a;
    @(negedge CLK_I);
    CFG_RD_I = 1'b0;
    chk("rvalid", 32'h1, {31'h0, CFG_RVALID_O});
    q = CFG_RDATA_O;
    @(negedge CLK_I);
    chk("rvalid_drop", 32'h0, {31'h0, CFG_RVALID_O});
  endtask

  task automatic chk_status;
    rd(8'hC8, d);
    // Upper half only: lower half belongs to device control
    chk("status", {10'h0, 1'b0, AUX_PWR_I, m_st}, d[31:16]);
    chk("err_out", {28'h0, m_st[0], m_st[1], m_st[2], m_st[3]}, {28'h0, ERR_STATUS_O});
  endtask

  task automatic chk_caps;
    rd(8'hCC, d);
    chk("caps", m_caps, d);
    chk("caps_out", m_caps, LINK_CAPS_O);
  endtask

  // Events and a write in the same cycle; a set wins over a clear
  task automatic step(input ppslc_err_t ev, input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, input logic [3:0] be);
    logic [3:0] clr;
    @(negedge CLK_I);
    ERR_EVT_I = ev;
    CFG_WR_I = wr;
    CFG_ADDR_I = a;
    CFG_WDATA_I = wd;
    CFG_BE_I = be;
    clr = (wr && a == 8'hC8 && be[2]) ? wd[19:16] : 4'h0;
    m_st = (m_st & ~clr) | {ev.unsup, ev.fatal, ev.nonfatal, ev.corr};
    @(negedge CLK_I);
    ERR_EVT_I = '0;
    CFG_WR_I = 1'b0;
    chk("err_step", {28'h0, m_st[0], m_st[1], m_st[2], m_st[3]}, {28'h0, ERR_STATUS_O});
  endtask

  task automatic load;
    ppslc_load_t l;
    l = ppslc_load_t'(22'($urandom));
    l.valid = 1'b1;
    @(negedge CLK_I);
    LOAD_I = l;
    @(negedge CLK_I);
    LOAD_I.valid = 1'b0;
    // Upstream keeps loaded clock PM, data link active reporting stays zero
    m_caps = {l.port_num, 3'h0, 1'b0, l.surprise, l.clk_pm, l.l1_lat, l.l0s_lat,
              l.aspm, 6'h04, 4'h2};
  endtask

  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end

  initial begin
    void'($urandom(20230));
    repeat (10) @(negedge CLK_I);
    RST_N_I = 1'b1;
    chk("caps_dn", 32'h0510_3012, dn_caps);
    chk_status();
    chk_caps();
    rd(8'hD4, d);
    chk("unmapped", 32'h0, d);
    step('0, 1'b1, 8'hCC, 32'hFFFF_FFFF, 4'hF);
    chk_caps();
    for (int i = 0; i < 300; i++) begin
      e = ppslc_err_t'(4'($urandom));
      step(e, 1'($urandom), ($urandom % 4 == 0) ? 8'hCC : 8'hC8, $urandom, 4'($urandom));
      if (i % 6 == 0) chk_status();
      if (i % 40 == 0) begin
        load();
        chk_caps();
      end
      if (i == 150) begin
        AUX_PWR_I = 1'b0;
        repeat (2) @(negedge CLK_I);
        chk_status();
      end
    end
    step('0, 1'b1, 8'hC8, 32'h000F_0000, 4'h4);
    chk_status();
    end_sim();
  end
endmodule
